//--- dv/apcr_peer.sv
// Radio peer model that hands received headers to the block.
`timescale 1ns/1ps
`default_nettype none
module apcr_peer
    import apcr_pkg::*;
(
    input wire logic pclk, // Clock.
    output var apcr_pkg::apcr_pkt_t rx_pkt // Header to the block.
);
    initial rx_pkt = '0;

    // Idle fields show the inverse so stale values are never mistaken for live ones.
    task automatic send(input logic [7:0] netid, input logic [15:0] addr);
    begin
        @(posedge pclk);
        rx_pkt <= '{valid: 1'b1, netid: netid, addr: addr};
        @(posedge pclk);
        rx_pkt <= '{valid: 1'b0, netid: ~netid, addr: ~addr};
    end
    endtask : send
endmodule : apcr_peer
`default_nettype wire

//--- dv/apcr_relay_asserts.sv
// Port checks for the parameter command interpreter.
`timescale 1ns/1ps
`default_nettype none
module apcr_asserts
    import apcr_pkg::*;
(
    input wire logic pclk, // Clock.
    input wire logic presetn, // Reset.
    input wire logic psel, // Select.
    input wire logic penable, // Enable.
    input wire logic [7:0] paddr, // Address.
    input wire logic pready, // Ready.
    input wire logic pslverr, // Error.
    input wire apcr_pkg::apcr_pkt_t rx_pkt, // Received.
    input wire apcr_pkg::apcr_pkt_t fwd_pkt, // Forwarded.
    input wire logic host_deliver, // Delivery.
    input wire logic host_tx_ready, // Host ready.
    input wire logic low_power_allowed, // Low power.
    input wire logic aux_idle, // Status.
    input wire logic upgrade_pending, // Upgrade.
    input wire logic log_enable, // Log.
    input wire logic [16:0] serial_baud, // Rate.
    input wire logic [11:0] wor_period_ms, // Period.
    input wire apcr_pkg::apcr_cfg_t cfg // Settings.
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic [12:0] low_r;

    // Counts edges spent reloading.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            low_r <= '0;
        else
            low_r <= aux_idle ? 13'h0 : low_r + 13'h1;
    end

    a_ready_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("ready not after one wait state");
    a_slverr_map: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}))
        else $error("error flag wrong for address");
    a_fwd_timing: assert property (fwd_pkt.valid |-> $past(rx_pkt.valid) && !low_power_allowed)
        else $error("forward without received header");
    a_fwd_swap: assert property (fwd_pkt.valid && $past(rx_pkt.netid) == cfg.addr[15:8] |-> fwd_pkt.netid == cfg.addr[7:0])
        else $error("forward network wrong");
    a_deliver_addr: assert property (host_deliver |-> $past(rx_pkt.valid) && $past(rx_pkt.addr) == cfg.addr)
        else $error("delivery with foreign address");
    a_relay_host: assert property (!low_power_allowed |-> !host_tx_ready && !host_deliver)
        else $error("host traffic while relaying");
    a_upg_rate: assert property (upgrade_pending |-> serial_baud == 17'h1c200 && log_enable)
        else $error("upgrade rate or log wrong");
    a_reload_low: assert property ($rose(aux_idle) |-> low_r >= 13'hf9e && low_r <= 13'hfa1)
        else $error("reload length wrong");
    a_chan_max: assert property (cfg.channel <= 7'h50)
        else $error("channel above limit");
    a_wor_period: assert property (wor_period_ms == ({9'h0, cfg.wor_period} + 12'h1) * 12'h1f4)
        else $error("wake period wrong");
endmodule : apcr_asserts

bind apcr_relay apcr_asserts chk_u (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .rx_pkt,
    .fwd_pkt, .host_deliver, .host_tx_ready, .low_power_allowed, .aux_idle, .upgrade_pending, .log_enable,
    .serial_baud, .wor_period_ms, .cfg);
`default_nettype wire

//--- dv/apcr_relay_tb_top.sv
// Self-checking bench for the parameter command interpreter.
`timescale 1ns/1ps
`default_nettype none
module apcr_relay_tb_top;
    import apcr_pkg::*;
    typedef struct packed {logic err; logic [31:0] mask; logic [31:0] val;} apcr_exp_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, power_high_variant = 1'b0, upgrade_restore = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [1:0] work_mode = MODE_CONFIG;
    logic pready, pslverr, upgrade_pending, host_deliver, host_tx_ready, low_power_allowed, aux_idle;
    logic log_enable, wor_sender;
    logic [16:0] serial_baud;
    logic [1:0] serial_parity;
    logic [9:0] air_rate_100bps;
    logic [7:0] packet_bytes;
    logic [11:0] wor_period_ms;
    logic [4:0] tx_power_dbm;
    apcr_pkt_t rx_pkt, fwd_pkt;
    apcr_cfg_t cfg;
    apcr_exp_t exp_q[$], e_cur;
    int err_total = 0, total_checks = 0, cyc = 0;
    logic [31:0] baud_tab [8] = '{32'h4b0, 32'h960, 32'h12c0, 32'h2580, 32'h4b00, 32'h9600, 32'he100, 32'h1c200};
    logic [31:0] air_tab [8] = '{32'h18, 32'h18, 32'h18, 32'h30, 32'h60, 32'hc0, 32'h180, 32'h271};
    logic [31:0] pwr_tab [8] = '{32'h16, 32'h11, 32'hd, 32'ha, 32'h1e, 32'h1b, 32'h18, 32'h15};
    logic [31:0] pkt_tab [4] = '{32'hf0, 32'h80, 32'h40, 32'h20};
    logic [4:0] rid [6] = '{5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h01};
    logic [19:0] rmax [6] = '{20'h0ffff, 20'h00050, 20'h000ff, 20'h0ffff, 20'h0ffff, 20'h00007};

    always #12.5 pclk = ~pclk;

    apcr_relay #(.UPG_CYCLES(32'hc8)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .work_mode, .power_high_variant, .upgrade_restore, .upgrade_pending, .rx_pkt, .fwd_pkt,
        .host_deliver, .host_tx_ready, .low_power_allowed, .aux_idle, .log_enable, .serial_baud, .serial_parity,
        .air_rate_100bps, .packet_bytes, .wor_sender, .wor_period_ms, .tx_power_dbm, .cfg);
    apcr_peer peer_u (.pclk, .rx_pkt);

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    begin
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask : cmp

    task automatic finish_test();
    begin
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask : finish_test

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input apcr_exp_t e);
    begin
        exp_q.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask : apb

    task automatic cmd(input logic [4:0] id, input logic [19:0] v, input logic ok);
    begin
        apb(1'b1, REG_CMD, {3'h0, id, 4'h0, v}, '0);
        apb(1'b0, REG_STATUS, 32'h0, '{1'b0, 32'h3, ok ? 32'h1 : 32'h2});
    end
    endtask : cmd

    task automatic wait_aux();
        int n = 0;
    begin
        while (aux_idle !== 1'b1 && n < 5000)
        begin
            @(negedge pclk);
            n++;
        end
        cmp({31'h0, n >= 3990 && n <= 4010}, 32'h1);
    end
    endtask : wait_aux

    task automatic do_reset(input logic restore);
    begin
        upgrade_restore <= restore;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(negedge pclk);
        cmp({30'h0, aux_idle, upgrade_pending}, {31'h0, restore});
        wait_aux();
    end
    endtask : do_reset

    // Takes the oldest note at every completed transfer.
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc > 40000)
        begin
            err_total++;
            finish_test();
        end
        else if (psel && penable && pready && exp_q.size() > 0)
        begin
            e_cur = exp_q.pop_front();
            cmp({31'h0, pslverr}, {31'h0, e_cur.err});
            cmp(prdata & e_cur.mask, e_cur.val);
        end
    end

    initial
    begin : main
        logic [1:0] p;
        void'($urandom(3501));
        do_reset(1'b0);
        for (int i = 0; i < 8; i++)
        begin
            p = 2'($urandom_range(3));
            cmd(5'h00, {15'h0, p, i[2:0]}, 1'b1);
            power_high_variant <= i[2];
            cmd(5'h01, 20'(i), 1'b1);
            cmd(5'h03, {16'h0, p[0], i[2:0]}, 1'b1);
            cmd(5'h02, {18'h0, i[1:0]}, 1'b1);
            cmd(5'h04, {18'h0, i[1:0]}, 1'b1);
            @(negedge pclk);
            cmp(32'(serial_baud), baud_tab[i]);
            cmp(32'(serial_parity), (p == 2'h3) ? 32'h0 : 32'(p));
            cmp(32'(air_rate_100bps), air_tab[i]);
            cmp(32'(wor_period_ms), 32'((i + 1) * 32'h1f4));
            cmp(32'(wor_sender), 32'(p[0]));
            cmp(32'(packet_bytes), pkt_tab[i[1:0]]);
            cmp(32'(tx_power_dbm), pwr_tab[i]);
        end
        for (int j = 0; j < 6; j++)
        begin
            cmd(rid[j], rmax[j] + 20'h1, 1'b0);
            cmd(rid[j], rmax[j], 1'b1);
        end
        for (int k = 5; k < 10; k++)
        begin
            cmd(5'(k), 20'h2, 1'b0);
            cmd(5'(k), 20'h1, 1'b1);
        end
        apb(1'b0, REG_CFG, 32'h0, '{1'b0, 32'h1f0000, 32'h1f0000});
        cmd(5'h10, 20'h0, 1'b0);
        cmd(5'h1f, 20'h0, 1'b0);
        cmd(5'h0d, 20'($urandom_range(65535)), 1'b1);
        apb(1'b1, 8'h18, 32'hffffffff, '{1'b1, 32'h0, 32'h0});
        apb(1'b0, 8'h14, 32'h0, '{1'b1, 32'hffffffff, 32'h0});
        cmd(5'h0a, 20'h00821, 1'b1);
        cmd(5'h0c, 20'h00005, 1'b1);
        apb(1'b0, REG_ADDR, 32'h0, '{1'b0, 32'hffffff, 32'h50821});
        cmp({31'h0, low_power_allowed}, 32'h1);
        work_mode <= MODE_NORMAL;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        cmp({30'h0, low_power_allowed, host_tx_ready}, 32'h0);
        cmd(5'h06, 20'h0, 1'b0);
        peer_u.send(8'h08, 16'h0821);
        @(negedge pclk);
        cmp({fwd_pkt.valid, fwd_pkt.netid, fwd_pkt.addr, host_deliver}, {1'b1, 8'h21, 16'h0821, 1'b0});
        peer_u.send(8'h21, 16'h0000);
        @(negedge pclk);
        cmp({fwd_pkt.valid, fwd_pkt.netid}, {1'b1, 8'h08});
        peer_u.send(8'h05, 16'h0821);
        @(negedge pclk);
        cmp({fwd_pkt.valid, host_deliver}, 32'h0);
        @(posedge pclk);
        work_mode <= MODE_CONFIG;
        cmd(5'h06, 20'h0, 1'b1);
        cmd(5'h00, 20'h3, 1'b1);
        work_mode <= MODE_NORMAL;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        cmp({30'h0, low_power_allowed, host_tx_ready}, 32'h3);
        peer_u.send(8'h05, 16'h0821);
        @(negedge pclk);
        cmp({31'h0, host_deliver}, 32'h1);
        peer_u.send(8'h05, 16'h0822);
        @(negedge pclk);
        cmp({31'h0, host_deliver}, 32'h0);
        cmd(5'h0f, 20'h0, 1'b0);
        cmp({31'h0, upgrade_pending}, 32'h0);
        work_mode <= MODE_CONFIG;
        cmd(5'h0f, 20'h0, 1'b1);
        @(negedge pclk);
        cmp({upgrade_pending, log_enable, serial_baud}, {2'h3, 17'h1c200});
        for (int n = 0; n < 400 && upgrade_pending === 1'b1; n++)
            @(negedge pclk);
        cmp({upgrade_pending, serial_baud}, {1'b0, 17'h2580});
        @(posedge pclk);
        do_reset(1'b1);
        cmp({31'h0, upgrade_pending}, 32'h0);
        @(posedge pclk);
        work_mode <= MODE_SLEEP;
        repeat (3) @(posedge pclk);
        work_mode <= MODE_CONFIG;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        cmp({31'h0, aux_idle}, 32'h0);
        cmd(5'h01, 20'h0, 1'b0);
        wait_aux();
        repeat (4) @(posedge pclk);
        finish_test();
    end
endmodule : apcr_relay_tb_top
`default_nettype wire

//--- inc/apcr_pkg.sv
// Shared constants and types for the parameter command interpreter.
package apcr_pkg;
    // Register byte offsets.
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CFG = 8'h08;
    localparam logic [7:0] REG_ADDR = 8'h0c;
    localparam logic [7:0] REG_CHAN = 8'h10;
    // Command word field positions.
    localparam int CMD_VAL_LSB = 0;
    localparam int CMD_VAL_W = 20;
    localparam int CMD_ID_LSB = 24;
    // Value limits.
    localparam logic [19:0] MAX_U16 = 20'h0ffff;
    localparam logic [19:0] MAX_CHAN = 20'h00050;
    localparam logic [19:0] MAX_U8 = 20'h000ff;
    localparam logic [19:0] MAX_U3 = 20'h00007;
    localparam logic [19:0] MAX_U2 = 20'h00003;
    localparam logic [19:0] MAX_U1 = 20'h00001;
    localparam logic [19:0] MAX_UART = 20'h0001f;
    localparam logic [19:0] MAX_WOR = 20'h0000f;
    // Working modes on the mode pins.
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_CONFIG = 2'h2;
    localparam logic [1:0] MODE_SLEEP = 2'h3;
    // Timing.
    localparam longint CLK_HZ = 40000000;
    localparam longint UPG_TIME_S = 60;
    localparam longint UPG_CYCLES_L = UPG_TIME_S * CLK_HZ;
    localparam longint RELOAD_TIME_US = 100;
    localparam logic [11:0] RELOAD_CYCLES = 12'((RELOAD_TIME_US * CLK_HZ) / 1000000);
    localparam logic [2:0] BAUD_UPGRADE = 3'h7;
    // Reset values of the settings.
    localparam logic [2:0] RST_BAUD = 3'h3;
    localparam logic [15:0] RST_ADDR = 16'h0000;

    typedef enum logic [4:0]
    {
        CMD_UART = 5'b00000,
        CMD_RATE = 5'b00001,
        CMD_PACKET = 5'b00010,
        CMD_WOR = 5'b00011,
        CMD_POWER = 5'b00100,
        CMD_TRANS = 5'b00101,
        CMD_ROUTER = 5'b00110,
        CMD_LBT = 5'b00111,
        CMD_ERSSI = 5'b01000,
        CMD_DRSSI = 5'b01001,
        CMD_ADDR = 5'b01010,
        CMD_CHANNEL = 5'b01011,
        CMD_NETID = 5'b01100,
        CMD_KEY = 5'b01101,
        CMD_DELAY = 5'b01110,
        CMD_UPGRADE = 5'b01111
    } apcr_cmd_t;

    typedef struct packed {
        logic [2:0] baud;
        logic [1:0] parity;
        logic [2:0] air;
        logic [1:0] packet;
        logic wor_role;
        logic [2:0] wor_period;
        logic [1:0] power;
        logic trans;
        logic router;
        logic lbt;
        logic erssi;
        logic drssi;
        logic [15:0] addr;
        logic [6:0] channel;
        logic [7:0] netid;
        logic [15:0] key;
        logic [15:0] delay;
    } apcr_cfg_t;

    localparam apcr_cfg_t CFG_RESET = '{baud: RST_BAUD, addr: RST_ADDR, default: '0};

    typedef struct packed {
        logic valid;
        logic [7:0] netid;
        logic [15:0] addr;
    } apcr_pkt_t;
endpackage : apcr_pkg

//--- logic/apcr_relay.sv
// Parameter command interpreter with upgrade timer and relay steering.
// Function
// RULE1: good command answers OK, bad answers ERR
// RULE2: 3-bit serial rate code, 1200 to 115200
// RULE3: 2-bit framing code, none/odd/even parity
// RULE4: 3-bit air rate code, 2.4k to 62.5k
// RULE5: 2-bit packet length code, 240 to 32
// RULE6: wake role bit and 3-bit period
// RULE7: 2-bit power code, two variants
// RULE8: one transport bit, transparent or fixed
// RULE9: relay, LBT, noise, data strength switches
// RULE10: address 0 to 65535, else ERR
// RULE11: channel 0 to 80, else ERR
// RULE12: network ID 0 to 255
// RULE13: key 0 to 65535
// RULE14: delayed sleep 0 to 65535
// RULE15: upgrade command only in configuration mode
// RULE16: upgrade exits after 60 s powered
// RULE17: upgrade forces 115200 and log output
// RULE18: relay starts on entering normal mode
// RULE19: forward between the two address networks
// RULE20: relay blocks host data and sleep
// RULE21: reload with status low after sleep/reset
// RULE22: deliver only packets with own address
`timescale 1ns/1ps
`default_nettype none
module apcr_relay
    import apcr_pkg::*;
#(
    parameter logic [31:0] UPG_CYCLES = 32'(UPG_CYCLES_L)
)
(
    input wire logic pclk, // Clock, 40 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error.
    input wire logic [1:0] work_mode, // Mode pins.
    input wire logic power_high_variant, // High-power variant strap.
    input wire logic upgrade_restore, // Upgrade still pending from before reset.
    output logic upgrade_pending, // Upgrade pending, kept across restart.
    input wire apcr_pkg::apcr_pkt_t rx_pkt, // Received packet header.
    output apcr_pkg::apcr_pkt_t fwd_pkt, // Packet to forward by radio.
    output logic host_deliver, // Pass received packet to host.
    output logic host_tx_ready, // Host data may be taken.
    output logic low_power_allowed, // Low-power operation allowed.
    output logic aux_idle, // Status output, low while reloading.
    output logic log_enable, // Upgrade log text enabled.
    output logic [16:0] serial_baud, // Effective serial rate in baud.
    output logic [1:0] serial_parity, // 0 none, 1 odd, 2 even.
    output logic [9:0] air_rate_100bps, // Air rate in units of 100 bit/s.
    output logic [7:0] packet_bytes, // Radio packet length limit.
    output logic wor_sender, // Wake role, 1 sender.
    output logic [11:0] wor_period_ms, // Wake period in ms.
    output logic [4:0] tx_power_dbm, // Transmit power in dBm.
    output apcr_pkg::apcr_cfg_t cfg // Current settings.
);
    import apcr_pkg::*;

    function automatic logic [16:0] baud_of(input logic [2:0] code);
        logic [16:0] b;
        b = 17'h0;
        unique case (code)
            3'h0: b = 17'd1200;
            3'h1: b = 17'd2400;
            3'h2: b = 17'd4800;
            3'h3: b = 17'd9600;
            3'h4: b = 17'd19200;
            3'h5: b = 17'd38400;
            3'h6: b = 17'd57600;
            3'h7: b = 17'd115200;
        endcase
        return b;
    endfunction : baud_of

    function automatic logic [9:0] air_of(input logic [2:0] code);
        logic [9:0] r;
        r = 10'd24;
        unique case (code)
            3'h0, 3'h1, 3'h2: r = 10'd24;
            3'h3: r = 10'd48;
            3'h4: r = 10'd96;
            3'h5: r = 10'd192;
            3'h6: r = 10'd384;
            3'h7: r = 10'd625;
        endcase
        return r;
    endfunction : air_of

    function automatic logic [4:0] power_of(input logic [1:0] code, input logic high);
        logic [4:0] p;
        p = 5'd0;
        unique case (code)
            2'h0: p = high ? 5'd30 : 5'd22;
            2'h1: p = high ? 5'd27 : 5'd17;
            2'h2: p = high ? 5'd24 : 5'd13;
            2'h3: p = high ? 5'd21 : 5'd10;
        endcase
        return p;
    endfunction : power_of

    // Bus decode.
    wire logic acc_phase = psel & penable;
    wire logic bus_done = acc_phase & pready;
    wire logic wr_done = bus_done & pwrite;
    wire logic addr_ok = (paddr == REG_CMD) | (paddr == REG_STATUS) | (paddr == REG_CFG) |
        (paddr == REG_ADDR) | (paddr == REG_CHAN);
    wire logic cmd_wr = wr_done & (paddr == REG_CMD);
    wire logic [4:0] cmd_id = pwdata[CMD_ID_LSB +: 5];
    wire logic [19:0] cmd_val = pwdata[CMD_VAL_LSB +: CMD_VAL_W];

    apcr_cfg_t cfg_r;
    apcr_cfg_t cfg_nxt;
    logic in_config;
    logic val_ok;
    logic upgrade_r;
    logic upgrade_nxt;
    logic [31:0] upg_cnt_r;
    logic [4:0] last_cmd_r;
    logic ok_r;
    logic err_r;
    logic [11:0] reload_cnt_r;
    logic [1:0] mode_prev_r;
    logic restore_seen_r;
    logic relay_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] rd_mux;
    apcr_pkt_t fwd_r;
    logic deliver_r;

    assign in_config = (work_mode == MODE_CONFIG) & (reload_cnt_r == 12'h0);

    // Value range check and field update per command.
    always_comb
    begin
        cfg_nxt = cfg_r;
        upgrade_nxt = 1'b0;
        val_ok = 1'b1;
        unique case (apcr_cmd_t'(cmd_id))
            // RULE2 RULE3: rate and framing
            CMD_UART: val_ok = cmd_val <= MAX_UART;
            // RULE4: air rate code
            CMD_RATE: val_ok = cmd_val <= MAX_U3;
            // RULE5: packet length code
            CMD_PACKET: val_ok = cmd_val <= MAX_U2;
            // RULE6: role and period
            CMD_WOR: val_ok = cmd_val <= MAX_WOR;
            // RULE7: power code
            CMD_POWER: val_ok = cmd_val <= MAX_U2;
            // RULE8 RULE9: single-bit switches
            CMD_TRANS, CMD_ROUTER, CMD_LBT, CMD_ERSSI, CMD_DRSSI: val_ok = cmd_val <= MAX_U1;
            // RULE10 RULE13 RULE14: 16-bit values
            CMD_ADDR, CMD_KEY, CMD_DELAY: val_ok = cmd_val <= MAX_U16;
            // RULE11: channel range
            CMD_CHANNEL: val_ok = cmd_val <= MAX_CHAN;
            // RULE12: network ID range
            CMD_NETID: val_ok = cmd_val <= MAX_U8;
            // RULE15: upgrade request
            CMD_UPGRADE: upgrade_nxt = 1'b1;
            default: val_ok = 1'b0;
        endcase
        unique case (apcr_cmd_t'(cmd_id))
            CMD_UART: {cfg_nxt.parity, cfg_nxt.baud} = cmd_val[4:0];
            CMD_RATE: cfg_nxt.air = cmd_val[2:0];
            CMD_PACKET: cfg_nxt.packet = cmd_val[1:0];
            CMD_WOR: {cfg_nxt.wor_role, cfg_nxt.wor_period} = cmd_val[3:0];
            CMD_POWER: cfg_nxt.power = cmd_val[1:0];
            CMD_TRANS: cfg_nxt.trans = cmd_val[0];
            CMD_ROUTER: cfg_nxt.router = cmd_val[0];
            CMD_LBT: cfg_nxt.lbt = cmd_val[0];
            CMD_ERSSI: cfg_nxt.erssi = cmd_val[0];
            CMD_DRSSI: cfg_nxt.drssi = cmd_val[0];
            CMD_ADDR: cfg_nxt.addr = cmd_val[15:0];
            CMD_CHANNEL: cfg_nxt.channel = cmd_val[6:0];
            CMD_NETID: cfg_nxt.netid = cmd_val[7:0];
            CMD_KEY: cfg_nxt.key = cmd_val[15:0];
            CMD_DELAY: cfg_nxt.delay = cmd_val[15:0];
            default: cfg_nxt = cfg_r;
        endcase
    end

    // RULE1: accept or refuse
    wire logic cmd_accept = cmd_wr & in_config & val_ok;
    wire logic cmd_refuse = cmd_wr & ~(in_config & val_ok);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_r <= CFG_RESET;
            last_cmd_r <= 5'h0;
            ok_r <= 1'b0;
            err_r <= 1'b0;
        end
        else if (cmd_wr)
        begin
            if (cmd_accept)
            begin
                cfg_r <= cfg_nxt;
            end
            last_cmd_r <= cmd_id;
            ok_r <= cmd_accept;
            err_r <= cmd_refuse;
        end
    end

    // The pending strap is caught at the first edge after reset release.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            restore_seen_r <= 1'b0;
            upgrade_r <= 1'b0;
            upg_cnt_r <= 32'h0;
        end
        else
        begin
            restore_seen_r <= 1'b1;
            if (!restore_seen_r && upgrade_restore)
            begin
                // RULE16: restart resumes upgrade
                upgrade_r <= 1'b1;
                upg_cnt_r <= 32'h0;
            end
            else if (cmd_accept && upgrade_nxt)
            begin
                // RULE15: enter upgrade mode
                upgrade_r <= 1'b1;
                upg_cnt_r <= 32'h0;
            end
            else if (upgrade_r)
            begin
                // RULE16: timed automatic exit
                if (upg_cnt_r >= UPG_CYCLES - 32'h1)
                begin
                    upgrade_r <= 1'b0;
                    upg_cnt_r <= 32'h0;
                end
                else
                begin
                    upg_cnt_r <= upg_cnt_r + 32'h1;
                end
            end
        end
    end

    // Reload window after reset and after leaving sleep.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reload_cnt_r <= RELOAD_CYCLES;
            mode_prev_r <= MODE_SLEEP;
        end
        else
        begin
            mode_prev_r <= work_mode;
            // RULE21: reload after sleep
            if (mode_prev_r == MODE_SLEEP && work_mode != MODE_SLEEP)
            begin
                reload_cnt_r <= RELOAD_CYCLES;
            end
            else if (reload_cnt_r != 12'h0)
            begin
                reload_cnt_r <= reload_cnt_r - 12'h1;
            end
        end
    end

    // Relay becomes active only on a switch into normal mode.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            relay_r <= 1'b0;
        end
        else if (work_mode != MODE_NORMAL)
        begin
            relay_r <= 1'b0;
        end
        // RULE18: start on mode switch
        else if (mode_prev_r != MODE_NORMAL && reload_cnt_r == 12'h0)
        begin
            relay_r <= cfg_r.router;
        end
    end

    wire logic from_high = rx_pkt.netid == cfg_r.addr[15:8];
    wire logic from_low = rx_pkt.netid == cfg_r.addr[7:0];
    wire logic addr_match = rx_pkt.addr == cfg_r.addr;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fwd_r <= '0;
            deliver_r <= 1'b0;
        end
        else
        begin
            // RULE19: cross-network forwarding
            fwd_r.valid <= rx_pkt.valid & relay_r & (from_high | from_low);
            fwd_r.netid <= from_high ? cfg_r.addr[7:0] : cfg_r.addr[15:8];
            fwd_r.addr <= rx_pkt.addr;
            // RULE22: address filter
            // RULE20: no host output in relay
            deliver_r <= rx_pkt.valid & ~relay_r & addr_match & (work_mode != MODE_CONFIG);
        end
    end

    // Read mux; the key is never readable.
    always_comb
    begin
        rd_mux = 32'h0;
        unique case (paddr)
            REG_STATUS: rd_mux = {14'h0, reload_cnt_r == 12'h0, relay_r, upgrade_r, last_cmd_r,
                work_mode, 6'h0, err_r, ok_r};
            REG_CFG: rd_mux = {11'h0, cfg_r.drssi, cfg_r.erssi, cfg_r.lbt, cfg_r.router, cfg_r.trans,
                cfg_r.power, cfg_r.wor_role, cfg_r.wor_period, cfg_r.packet, cfg_r.air, cfg_r.parity,
                cfg_r.baud};
            REG_ADDR: rd_mux = {8'h0, cfg_r.netid, cfg_r.addr};
            REG_CHAN: rd_mux = {9'h0, cfg_r.channel, cfg_r.delay};
            default: rd_mux = 32'h0;
        endcase
    end

    // One wait state: ready rises in the second access cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end
        else
        begin
            pready_r <= acc_phase & ~pready_r;
            pslverr_r <= acc_phase & ~pready_r & ~addr_ok;
            if (acc_phase && !pready_r && !pwrite)
            begin
                prdata_r <= rd_mux;
            end
        end
    end

    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign prdata = prdata_r;
    assign cfg = cfg_r;
    assign fwd_pkt = fwd_r;
    assign host_deliver = deliver_r;
    // RULE20: relay blocks host and sleep
    assign host_tx_ready = ~relay_r & (reload_cnt_r == 12'h0);
    assign low_power_allowed = ~relay_r;
    // RULE21: status low while reloading
    assign aux_idle = reload_cnt_r == 12'h0;
    assign upgrade_pending = upgrade_r;
    // RULE17: upgrade rate and log
    assign log_enable = upgrade_r;
    assign serial_baud = baud_of(upgrade_r ? BAUD_UPGRADE : cfg_r.baud);
    assign serial_parity = (cfg_r.parity == 2'h3) ? 2'h0 : cfg_r.parity;
    assign air_rate_100bps = air_of(cfg_r.air);
    assign packet_bytes = (cfg_r.packet == 2'h0) ? 8'd240 : 8'(9'd256 >> cfg_r.packet);
    assign wor_sender = cfg_r.wor_role;
    assign wor_period_ms = 12'(({9'h0, cfg_r.wor_period} + 12'h1) * 12'd500);
    assign tx_power_dbm = power_of(cfg_r.power, power_high_variant);
endmodule : apcr_relay
`default_nettype wire
